// ### core/radio_rx_measurement_regs.v
// Purpose: receive measurement register bank of the 2.4 ghz transceiver
// Assumes: cpu register port synchronous to clk; analog front end gives
//          power above base in 1 db steps and carrier sense as levels
// Notes:   radio state machine lives outside; it reports state and rate here
`include "rx_meas_regs.vh"

module radio_rx_measurement_regs #(
  parameter ED_LONG_CYCLES  = `ED_LONG_CYCLES,
  parameter ED_SHORT_CYCLES = `ED_SHORT_CYCLES
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // cpu register port
  input  wire [8:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // radio state and front end
  input  wire       rx_state,
  input  wire       basic_rx_state,
  input  wire       rx_on_state,
  input  wire [1:0] data_rate,
  input  wire       frame_end,
  input  wire       frame_crc_ok,
  input  wire [7:0] power_db,
  input  wire       carrier_sensed,
  input  wire [1:0] noise_bits,
  input  wire       auto_ed_start,
  // results toward radio and cpu
  output reg        receive_end_irq,
  output reg        assess_done_irq,
  output reg        assess_done_flag,
  output reg        assess_result_flag,
  output reg        channel_valid,
  output reg  [11:0] carrier_mhz,
  output reg  [1:0] carrier_threshold
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg        crc_valid_reg;
  reg  [1:0] random_bits;
  reg  [4:0] strength_reg;
  reg  [7:0] energy_result;
  reg        assess_request;
  reg  [1:0] assess_mode_sel;
  reg  [4:0] channel_reg;
  reg  [1:0] carrier_thr_reg;
  reg  [3:0] energy_threshold;
  reg  [7:0] rnd_count_reg;
  reg  [8:0] rssi_count_reg;
  reg        assess_busy_reg;

  wire       wr_ed;
  wire       wr_cca;
  wire       wr_thr;
  wire       ed_start;
  wire       ed_short;
  wire       ed_done;
  wire [7:0] ed_value;
  wire [4:0] strength_next;
  wire [7:0] power_clip;
  wire [7:0] strength_calc;
  wire       energy_busy;
  reg        assess_busy_next;

  // reset images, so fields can be sliced out of the packed reset bytes
  localparam [7:0] CTRL_RESET = `RST_CHANNEL_ASSESS_CONTROL;
  localparam [7:0] THR_RESET  = `RST_CHANNEL_ASSESS_THRESH;

  assign wr_ed  = reg_wr && (reg_addr == `ADDR_ENERGY_DETECT_RESULT);
  assign wr_cca = reg_wr && (reg_addr == `ADDR_CHANNEL_ASSESS_CONTROL);
  assign wr_thr = reg_wr && (reg_addr == `ADDR_CHANNEL_ASSESS_THRESH);

  // ------------------------------------------------------------
  // energy detection
  // ------------------------------------------------------------
  // a manual start comes from a register write or the assessment launch
  assign ed_start = wr_ed || auto_ed_start || (wr_cca && reg_wdata[`ASSESS_REQ_BIT]);
  // manual starts stay long while in rx_on; automatic ones shorten at high rate
  assign ed_short = (data_rate != `RATE_STANDARD) &&
                    !((wr_ed || wr_cca) && rx_on_state);

  energy_integrator #(
    .LONG_CYCLES  (ED_LONG_CYCLES),
    .SHORT_CYCLES (ED_SHORT_CYCLES)
  ) u_energy (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (ed_start),
    .use_short (ed_short),
    .power_db  (power_db),
    .done      (ed_done),
    .result    (ed_value)
  );

  // ------------------------------------------------------------
  // signal strength quantiser
  // ------------------------------------------------------------
  // code n covers base+3(n-1); below base gives 0, clipped at top code
  assign power_clip    = (power_db > `STRENGTH_TOP_DB) ? `STRENGTH_TOP_DB : power_db;
  assign strength_calc = power_clip / `STRENGTH_STEP_DB + 8'h01;
  assign strength_next = (power_db == 8'h00) ? 5'h00 :
                         (power_db >= `STRENGTH_TOP_DB) ? `STRENGTH_TOP :
                         strength_calc[4:0];

  // ------------------------------------------------------------
  // assessment decision
  // ------------------------------------------------------------
  // threshold is base + 2*field, compared against the finished energy value
  assign energy_busy = ed_value > {3'b000, energy_threshold, 1'b0};

  always @* begin
    case (assess_mode_sel)
      `MODE_CS_OR_ED:  assess_busy_next = carrier_sensed | energy_busy;
      `MODE_ED_ONLY:   assess_busy_next = energy_busy;
      `MODE_CS_ONLY:   assess_busy_next = carrier_sensed;
      `MODE_CS_AND_ED: assess_busy_next = carrier_sensed & energy_busy;
      default:         assess_busy_next = energy_busy;
    endcase
  end

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_valid_reg      <= 1'b0;
      random_bits        <= 2'h0;
      strength_reg       <= 5'h00;
      energy_result      <= `ENERGY_NONE;
      assess_request     <= 1'b0;
      assess_mode_sel    <= CTRL_RESET[`ASSESS_MODE_MSB:`ASSESS_MODE_LSB];
      channel_reg        <= CTRL_RESET[`CHANNEL_MSB:`CHANNEL_LSB];
      carrier_thr_reg    <= THR_RESET[`CARRIER_THR_MSB:`CARRIER_THR_LSB];
      energy_threshold   <= THR_RESET[`ENERGY_THR_MSB:`ENERGY_THR_LSB];
      rnd_count_reg      <= 8'h00;
      rssi_count_reg     <= 9'h000;
      assess_busy_reg    <= 1'b0;
      receive_end_irq    <= 1'b0;
      assess_done_irq    <= 1'b0;
      assess_done_flag   <= 1'b0;
      assess_result_flag <= 1'b0;
    end else begin
      receive_end_irq <= frame_end;
      assess_done_irq <= 1'b0;
      if (frame_end)
        crc_valid_reg <= frame_crc_ok;

      // random bits sampled once per microsecond
      if (rnd_count_reg == `RANDOM_CYCLES - 1) begin
        rnd_count_reg <= 8'h00;
        if (basic_rx_state)
          random_bits <= noise_bits;
      end else begin
        rnd_count_reg <= rnd_count_reg + 8'h01;
      end

      if (rssi_count_reg == `STRENGTH_CYCLES - 1) begin
        rssi_count_reg <= 9'h000;
        if (rx_state)
          strength_reg <= strength_next;
      end else begin
        rssi_count_reg <= rssi_count_reg + 9'h001;
      end

      if (ed_done)
        energy_result <= ed_value;

      // request bit never stores: launch happens on the write itself
      assess_request <= 1'b0;
      if (wr_cca) begin
        assess_mode_sel <= reg_wdata[`ASSESS_MODE_MSB:`ASSESS_MODE_LSB];
        channel_reg     <= reg_wdata[`CHANNEL_MSB:`CHANNEL_LSB];
        if (reg_wdata[`ASSESS_REQ_BIT]) begin
          assess_busy_reg  <= 1'b1;
          assess_done_flag <= 1'b0;
        end
      end
      if (wr_thr) begin
        carrier_thr_reg  <= reg_wdata[`CARRIER_THR_MSB:`CARRIER_THR_LSB];
        energy_threshold <= reg_wdata[`ENERGY_THR_MSB:`ENERGY_THR_LSB];
      end

      if (assess_busy_reg && ed_done) begin
        assess_busy_reg    <= 1'b0;
        assess_done_irq    <= 1'b1;
        assess_done_flag   <= 1'b1;
        assess_result_flag <= !assess_busy_next;
      end
    end
  end

  // ------------------------------------------------------------
  // channel to carrier frequency
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_valid     <= 1'b0;
      carrier_mhz       <= 12'h000;
      carrier_threshold <= 2'h0;
    end else begin
      channel_valid     <= (channel_reg >= `CHANNEL_FIRST) && (channel_reg <= `CHANNEL_LAST);
      carrier_mhz       <= `CARRIER_FIRST_MHZ +
                           `CARRIER_STEP_MHZ * {7'h00, channel_reg - `CHANNEL_FIRST};
      carrier_threshold <= carrier_thr_reg;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        // writes to this address are ignored
        `ADDR_RX_QUALITY_STATUS:      reg_rdata <= {crc_valid_reg, random_bits, strength_reg};
        `ADDR_ENERGY_DETECT_RESULT:   reg_rdata <= energy_result;
        `ADDR_CHANNEL_ASSESS_CONTROL: reg_rdata <= {assess_request, assess_mode_sel, channel_reg};
        `ADDR_CHANNEL_ASSESS_THRESH:  reg_rdata <= {2'b00, carrier_thr_reg, energy_threshold};
        default:                      reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // radio_rx_measurement_regs

// ### shared/rx_meas_regs.vh
// Purpose: address map, field positions, reset values and timing for rx measurement regs
// Assumes: 250 MHz core clock
// Notes:   included by the rx measurement register bank and its energy integrator
`ifndef RX_MEAS_REGS_VH
`define RX_MEAS_REGS_VH

// ------------------------------------------------------------
// register addresses (extended i/o space)
// ------------------------------------------------------------
`define ADDR_RX_QUALITY_STATUS      9'h146
`define ADDR_ENERGY_DETECT_RESULT   9'h147
`define ADDR_CHANNEL_ASSESS_CONTROL 9'h148
`define ADDR_CHANNEL_ASSESS_THRESH  9'h149

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_RX_QUALITY_STATUS      8'h00
`define RST_ENERGY_DETECT_RESULT   8'hFF
`define RST_CHANNEL_ASSESS_CONTROL 8'h2B
`define RST_CHANNEL_ASSESS_THRESH  8'h07

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CRC_VALID_BIT     7
`define RANDOM_MSB        6
`define RANDOM_LSB        5
`define STRENGTH_MSB      4
`define STRENGTH_LSB      0
`define ASSESS_REQ_BIT    7
`define ASSESS_MODE_MSB   6
`define ASSESS_MODE_LSB   5
`define CHANNEL_MSB       4
`define CHANNEL_LSB       0
`define CARRIER_THR_MSB   5
`define CARRIER_THR_LSB   4
`define ENERGY_THR_MSB    3
`define ENERGY_THR_LSB    0

// ------------------------------------------------------------
// assessment modes
// ------------------------------------------------------------
`define MODE_CS_OR_ED  2'h0
`define MODE_ED_ONLY   2'h1
`define MODE_CS_ONLY   2'h2
`define MODE_CS_AND_ED 2'h3

// ------------------------------------------------------------
// codes and scale
// ------------------------------------------------------------
`define STRENGTH_TOP     5'h1C
`define STRENGTH_STEP_DB 8'h03
`define STRENGTH_TOP_DB  8'h50
`define CARRIER_FIRST_MHZ 12'h965
`define CARRIER_STEP_MHZ  12'h005
`define ENERGY_TOP       8'h54
`define ENERGY_NONE      8'hFF
`define CHANNEL_FIRST    5'h0B
`define CHANNEL_LAST     5'h1A
`define RATE_STANDARD    2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ          250
`define RANDOM_PERIOD_NS 1000
`define STRENGTH_PERIOD_NS 2000
`define ED_LONG_US       128
`define ED_SHORT_US      32
`define RANDOM_CYCLES    ((`RANDOM_PERIOD_NS * `CLK_MHZ) / 1000)
`define STRENGTH_CYCLES  ((`STRENGTH_PERIOD_NS * `CLK_MHZ) / 1000)
`define ED_LONG_CYCLES   (`ED_LONG_US * `CLK_MHZ)
`define ED_SHORT_CYCLES  (`ED_SHORT_US * `CLK_MHZ)

`endif

// ### core/energy_integrator.v
// Purpose: energy detection accumulator over a programmable window
// Assumes: power sample is 1 db per lsb above base level, valid every cycle
// Notes:   result is the average over the window, clipped to the top code
`include "rx_meas_regs.vh"

module energy_integrator #(
  parameter LONG_CYCLES  = `ED_LONG_CYCLES,
  parameter SHORT_CYCLES = `ED_SHORT_CYCLES
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire       start,
  input  wire       use_short,
  // sample
  input  wire [7:0] power_db,
  // result
  output reg        done,
  output reg  [7:0] result
);

  reg  [15:0] count_reg;
  reg  [23:0] sum_reg;
  reg         busy_reg;
  reg  [15:0] length_reg;
  wire [23:0] sum_next;
  wire [23:0] average;

  assign sum_next = sum_reg + {16'h0000, power_db};
  // window lengths are powers of two apart; dividing by length keeps 1 db steps
  assign average  = sum_next / {8'h00, length_reg};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg  <= 16'h0000;
      sum_reg    <= 24'h000000;
      busy_reg   <= 1'b0;
      length_reg <= 16'h0001;
      done       <= 1'b0;
      result     <= `ENERGY_NONE;
    end else begin
      done <= 1'b0;
      if (start) begin
        // a restart mid window discards the partial sum
        busy_reg   <= 1'b1;
        count_reg  <= 16'h0000;
        sum_reg    <= 24'h000000;
        length_reg <= use_short ? SHORT_CYCLES[15:0] : LONG_CYCLES[15:0];
      end else if (busy_reg) begin
        sum_reg   <= sum_next;
        count_reg <= count_reg + 16'h0001;
        if (count_reg == length_reg - 16'h0001) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
          result   <= (average > {16'h0000, `ENERGY_TOP}) ? `ENERGY_TOP : average[7:0];
        end
      end
    end
  end

endmodule // energy_integrator

// ### test/radio_rx_measurement_regs_sva.sv
// Purpose: port checks for the rx measurement register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   window bounds follow the bound instance parameters
module radio_rx_measurement_regs_sva #(
  parameter int ED_LONG_CYCLES  = 16,
  parameter int ED_SHORT_CYCLES = 4
) (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // register port
  input logic [8:0]  reg_addr,
  input logic        reg_wr,
  input logic [7:0]  reg_wdata,
  // radio side
  input logic [1:0]  data_rate,
  input logic        frame_end,
  input logic        receive_end_irq,
  input logic        assess_done_irq,
  input logic        assess_done_flag,
  input logic        channel_valid,
  input logic [11:0] carrier_mhz,
  input logic [1:0]  carrier_threshold
);
  localparam int LO = ED_LONG_CYCLES;
  localparam int HI = ED_LONG_CYCLES + 4;
  logic thr_wr;
  logic ch_wr;
  assign thr_wr = reg_wr && reg_addr == 9'h149;
  assign ch_wr  = reg_wr && reg_addr == 9'h148;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rx_end_irq: assert property (frame_end |=> receive_end_irq)
    else $error("receive end pulse missing");
  chk_rx_end_cause: assert property (receive_end_irq |-> $past(frame_end))
    else $error("receive end pulse without frame end");
  chk_done_flag: assert property (assess_done_irq |-> assess_done_flag)
    else $error("done flag low at done pulse");
  chk_flag_rise: assert property ($rose(assess_done_flag) |-> assess_done_irq)
    else $error("done flag rose without done pulse");
  chk_assess_time: assert property ((ch_wr && reg_wdata[7] && data_rate == 2'h0)
    |-> ##[LO:HI] assess_done_irq) else $error("assessment window length wrong");
  chk_channel_map: assert property (channel_valid |-> (carrier_mhz >= 12'h965
    && carrier_mhz <= 12'h9B0 && carrier_mhz % 12'h005 == 12'h000))
    else $error("carrier frequency off grid");
  chk_thr_cause: assert property ((carrier_threshold != $past(carrier_threshold))
    |-> ($past(thr_wr) || $past(thr_wr, 2))) else $error("threshold moved unwritten");
  chk_freq_cause: assert property (($past(rst_n, 2) && carrier_mhz != $past(carrier_mhz))
    |-> ($past(ch_wr) || $past(ch_wr, 2))) else $error("frequency moved unwritten");
endmodule // radio_rx_measurement_regs_sva

bind radio_rx_measurement_regs radio_rx_measurement_regs_sva #(
  .ED_LONG_CYCLES(ED_LONG_CYCLES), .ED_SHORT_CYCLES(ED_SHORT_CYCLES)) i_sva (
  .clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .data_rate, .frame_end, .receive_end_irq,
  .assess_done_irq, .assess_done_flag, .channel_valid, .carrier_mhz, .carrier_threshold);

// ### test/radio_rx_measurement_regs_tb.sv
// Purpose: self-checking bench for the rx measurement register bank
// Assumes: short energy windows set by parameter to keep the run brief
// Notes:   reads are queued by the driver and compared by a monitor
module radio_rx_measurement_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 16;
  localparam int SHORT = 4;
  logic        clk, rst_n, reg_wr, reg_rd, rx_state, basic_rx_state, rx_on_state;
  logic        frame_end, frame_crc_ok, carrier_sensed, auto_ed_start, rd_seen;
  logic        receive_end_irq, assess_done_irq, assess_done_flag, assess_result_flag;
  logic        channel_valid, cs, ed, busy;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, power_db, d, exp_q[$], mask_q[$];
  logic [1:0]  data_rate, noise_bits, carrier_threshold;
  logic [11:0] carrier_mhz;
  logic [7:0]  ed_tab [4][5];
  int          failures, checked, seed, i, k;

  radio_rx_measurement_regs #(.ED_LONG_CYCLES(LONG), .ED_SHORT_CYCLES(SHORT)) i_dut (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_state,
    .basic_rx_state, .rx_on_state, .data_rate, .frame_end, .frame_crc_ok, .power_db,
    .carrier_sensed, .noise_bits, .auto_ed_start, .receive_end_irq, .assess_done_irq,
    .assess_done_flag, .assess_result_flag, .channel_valid, .carrier_mhz,
    .carrier_threshold);

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [8:0] a, logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a; reg_wdata = v; reg_wr = 1;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask

  task automatic rd(logic [8:0] a, logic [7:0] e, logic [7:0] m);
    @(posedge clk);
    #1 reg_addr = a; reg_rd = 1;
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge clk);
    #1 reg_rd = 0;
  endtask

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // read data stands from the edge after the read strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      cmp("reg_rdata", 16'(exp_q[0] & mask_q[0]), 16'(reg_rdata & mask_q[0]));
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
    rd_seen <= reg_rd;
  end

  initial begin
    #40000;
    failures++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hA3D6A5D7;
    {failures, checked, rd_seen, rst_n, reg_wr, reg_rd, rx_state, basic_rx_state} = 0;
    {frame_end, frame_crc_ok, carrier_sensed, auto_ed_start, data_rate} = 0;
    {reg_addr, reg_wdata, power_db, noise_bits} = 0;
    rx_on_state = 1;
    ed_tab = '{'{0, 0, 8'h60, 8'hFF, 8'h54}, '{1, 0, 8'h20, 8'h54, 8'h20},
               '{1, 1, 8'h00, 8'h00, 8'h00}, '{0, 1, 8'h05, 8'h00, 8'h05}};
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    rd(9'h146, 8'h00, 8'hFF);
    rd(9'h147, 8'hFF, 8'hFF);
    rd(9'h148, 8'h2B, 8'hFF);
    rd(9'h149, 8'h07, 8'hFF);
    rd(9'h14A, 8'h00, 8'hFF);
    wr(9'h146, 8'hFF);
    rd(9'h146, 8'h00, 8'hFF);
    for (i = 0; i < 4; i++) begin
      data_rate = ed_tab[i][0][1:0];
      power_db = ed_tab[i][2];
      if (ed_tab[i][1][0]) begin
        @(posedge clk);
        #1 auto_ed_start = 1;
        @(posedge clk);
        #1 auto_ed_start = 0;
      end else wr(9'h147, 8'($random(seed)));
      repeat (8) @(posedge clk);
      rd(9'h147, ed_tab[i][3], 8'hFF);
      repeat (LONG + 8) @(posedge clk);
      rd(9'h147, ed_tab[i][4], 8'hFF);
      rd(9'h146, 8'h00, 8'hFF);
    end
    data_rate = 0;
    d = 8'($random(seed)) & 8'h3F;
    wr(9'h149, d);
    rd(9'h149, d, 8'h3F);
    cmp("carrier_threshold", 16'(d[5:4]), 16'(carrier_threshold));
    for (i = 10; i < 28; i++) begin
      wr(9'h148, 8'(i));
      repeat (2) @(posedge clk);
      #1 cmp("channel_valid", 16'(i >= 11 && i <= 26), 16'(channel_valid));
      if (i >= 11 && i <= 26) cmp("carrier_mhz", 16'(2405 + 5 * (i - 11)), 16'(carrier_mhz));
    end
    wr(9'h149, 8'h07);
    rx_state = 1;
    for (i = 0; i < 16; i++) begin
      cs = i[2];
      ed = i[3];
      carrier_sensed = cs;
      // energy must exceed twice the threshold, so 14 is the idle boundary
      power_db = ed ? 8'h0F : 8'h0E;
      case (i[1:0])
        0: busy = cs | ed;
        1: busy = ed;
        2: busy = cs;
        default: busy = cs & ed;
      endcase
      wr(9'h148, {1'b1, 2'(i), 5'h0B});
      for (k = 0; k < 100 && assess_done_irq !== 1'b1; k++) @(negedge clk);
      cmp("assess_done_irq", 16'h0001, 16'(assess_done_irq));
      cmp("assess_done_flag", 16'h0001, 16'(assess_done_flag));
      cmp("assess_result_flag", 16'(!busy), 16'(assess_result_flag));
      rd(9'h148, {1'b0, 2'(i), 5'h0B}, 8'hFF);
    end
    power_db = 8'h1E;
    repeat (520) @(posedge clk);
    rd(9'h146, 8'h0B, 8'h1F);
    power_db = 8'h5A;
    repeat (520) @(posedge clk);
    rd(9'h146, 8'h1C, 8'h1F);
    rx_state = 0;
    power_db = 8'h1E;
    repeat (520) @(posedge clk);
    rd(9'h146, 8'h1C, 8'h1F);
    for (i = 1; i >= 0; i--) begin
      @(posedge clk);
      #1 frame_crc_ok = i[0]; frame_end = 1;
      @(posedge clk);
      #1 frame_end = 0;
      cmp("receive_end_irq", 16'h0001, 16'(receive_end_irq));
      rd(9'h146, {i[0], 7'h00}, 8'h80);
    end
    frame_crc_ok = 1;
    rd(9'h146, 8'h00, 8'h80);
    d = 8'($random(seed));
    basic_rx_state = 1;
    noise_bits = d[1:0];
    repeat (300) @(posedge clk);
    rd(9'h146, {1'b0, d[1:0], 5'h00}, 8'h60);
    basic_rx_state = 0;
    noise_bits = ~d[1:0];
    repeat (300) @(posedge clk);
    rd(9'h146, {1'b0, d[1:0], 5'h00}, 8'h60);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // radio_rx_measurement_regs_tb
